// >>> hcp_consts.svh
`ifndef HCP_CONSTS_SVH
`define HCP_CONSTS_SVH

// Transfer size encodings on the two size lines
`define HCP_TSZ_BYTE   2'h1
`define HCP_TSZ_HALF   2'h2
`define HCP_TSZ_WORD   2'h0

// Port width selection codes
`define HCP_WIDTH_8    2'h0
`define HCP_WIDTH_16   2'h1
`define HCP_WIDTH_32   2'h2

// Byte lane masks for parity lanes in use
`define HCP_LANES_8    4'h1
`define HCP_LANES_16   4'h3
`define HCP_LANES_32   4'hF

// Reset values
`define HCP_DATA_RST   32'h0000_0000
`define HCP_PAR_RST    4'h0
`define HCP_ADDR_RST   18'h0_0000
`define HCP_CTL_IDLE   4'hF
`define HCP_CTL_OFF    4'h0
`define HCP_PIN_RST    36'h0_0000_0000

// Clock line stays an input while the port owns the pins
`define HCP_CTL_OE_PORT 4'h7

`endif

// >>> hcp_pkg.sv
package hcp_pkg;

  typedef enum logic [2:0] {
    HCP_IDLE  = 3'b000,
    HCP_WAIT  = 3'b001,
    HCP_RESP  = 3'b010,
    HCP_HOLD  = 3'b011
  } hcp_state_t;

  typedef enum logic [1:0] {
    HCP_ANS_ACK   = 2'b00,
    HCP_ANS_ERR   = 2'b01,
    HCP_ANS_RETRY = 2'b10
  } hcp_answer_t;

  // Request from the external master, as sampled on the pins
  typedef struct packed {
    logic        sel;
    logic        read;
    logic [1:0]  size;
    logic        burst;
    logic [17:0] addr;
    logic [31:0] wdata;
    logic [3:0]  wpar;
  } hcp_req_t;

  // Request towards the internal system bus
  typedef struct packed {
    logic        valid;
    logic        read;
    logic [1:0]  size;
    logic        burst;
    logic [17:0] addr;
    logic [31:0] wdata;
  } hcp_sys_req_t;

  // Answer from the internal system bus
  typedef struct packed {
    logic        done;
    logic        error;
    logic        retry;
    logic [31:0] rdata;
  } hcp_sys_rsp_t;

endpackage

// >>> hcp_parity.sv
`timescale 1ns/1ps
`include "hcp_consts.svh"

// Even parity per byte lane; unused lanes forced to zero.
module hcp_parity
  import hcp_pkg::*;
(
  input  wire logic [31:0] data_in,
  input  wire logic [1:0]  width_sel_in,
  output logic      [3:0]  parity_out,
  output logic      [3:0]  lanes_out
);

  function automatic logic [3:0] lane_mask(input logic [1:0] w);
    case (w)
      `HCP_WIDTH_8:  lane_mask = `HCP_LANES_8;
      `HCP_WIDTH_16: lane_mask = `HCP_LANES_16;
      default:       lane_mask = `HCP_LANES_32;
    endcase
  endfunction

  // Big-endian numbering: parity lane 0 covers D[0:7] = data[31:24]
  always_comb begin
    lanes_out     = lane_mask(width_sel_in);
    parity_out[0] = ^data_in[31:24] & lanes_out[0];
    parity_out[1] = ^data_in[23:16] & lanes_out[1];
    parity_out[2] = ^data_in[15:8]  & lanes_out[2];
    parity_out[3] = ^data_in[7:0]   & lanes_out[3];
  end

endmodule

// >>> hcp_gpio.sv
`timescale 1ns/1ps
`include "hcp_consts.svh"

// Pin mux: when the port is off, pins act as user I/O.
module hcp_gpio
  import hcp_pkg::*;
(
  input  wire logic        port_en_in,
  input  wire logic [3:0]  port_ctl_in,
  input  wire logic [3:0]  user_ctl_in,
  input  wire logic [3:0]  user_ctl_oe_in,
  input  wire logic [35:0] port_dat_in,
  input  wire logic        port_dat_oe_in,
  input  wire logic [35:0] user_dat_in,
  input  wire logic [35:0] user_dat_oe_in,
  output logic      [3:0]  ctl_out,
  output logic      [3:0]  ctl_oe_out,
  output logic      [35:0] dat_out,
  output logic      [35:0] dat_oe_out
);

  always_comb begin
    if (port_en_in) begin
      ctl_out    = port_ctl_in;
      ctl_oe_out = `HCP_CTL_OE_PORT;
      dat_out    = port_dat_in;
      dat_oe_out = {36{port_dat_oe_in}};
    end else begin
      ctl_out    = user_ctl_in;
      ctl_oe_out = user_ctl_oe_in;
      dat_out    = user_dat_in;
      dat_oe_out = user_dat_oe_in;
    end
  end

endmodule

// >>> hcp_port.sv
`timescale 1ns/1ps
`include "hcp_consts.svh"

// Operation
// - Acknowledge goes low when write data is taken or read data is driven.
// - A system bus error answers with transfer error acknowledge low instead.
// - Retry asks the master to drop the bus and repeat the cycle later.
// - Everything launches and samples on the rising host bus clock edge.
// - The host bus clock also clocks the internal system bus side.
// - Width select (8, 16 or 32 bits) sets the parity lanes only; reads drive all 32 data lines.
// - Master drives data on writes, the port drives it on reads only.
// - Parity width is 1, 2 or 4 bits, one bit per byte lane in use.
// - Parity bit n covers big-endian data byte n.
// - With the port disabled its pins serve as user I/O after configuration.
// - The port answers only with chip select low low and chip select high high.
module hcp_port
  import hcp_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        port_en_in,
  input  wire logic        cfg_done_in,
  input  wire logic [1:0]  width_sel_in,
  input  wire logic        chip_select_low_n_in,
  input  wire logic        chip_select_high_in,
  input  wire logic        transfer_start_n_in,
  input  wire logic        read_not_write_in,
  input  wire logic [1:0]  transfer_size_in,
  input  wire logic        burst_indicator_n_in,
  input  wire logic [17:0] addr_in,
  input  wire logic [31:0] data_in,
  input  wire logic [3:0]  byte_lane_parity_in,
  input  wire logic [3:0]  user_ctl_in,
  input  wire logic [3:0]  user_ctl_oe_in,
  input  wire logic [35:0] user_dat_in,
  input  wire logic [35:0] user_dat_oe_in,
  input  wire logic        sys_done_in,
  input  wire logic        sys_error_in,
  input  wire logic        sys_retry_in,
  input  wire logic [31:0] sys_rdata_in,
  output logic             sys_clk_out,
  output logic             sys_valid_out,
  output logic             sys_read_out,
  output logic      [1:0]  sys_size_out,
  output logic             sys_burst_out,
  output logic      [17:0] sys_addr_out,
  output logic      [31:0] sys_wdata_out,
  output logic             wr_parity_err_out,
  output logic      [3:0]  ctl_out,
  output logic      [3:0]  ctl_oe_out,
  output logic      [35:0] dat_out,
  output logic      [35:0] dat_oe_out
);

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  hcp_state_t   state_reg;
  hcp_state_t   state_next;
  hcp_sys_req_t sreq_reg;
  hcp_req_t     pin_req;
  logic         ack_n_reg;
  logic         tea_n_reg;
  logic         rtry_n_reg;
  logic [31:0]  rdata_reg;
  logic [3:0]   rpar_reg;
  logic         drive_reg;
  logic         perr_reg;
  logic [3:0]   rd_par;
  logic [3:0]   wr_par;
  logic [3:0]   lanes;
  logic         en;
  logic         hit;
  logic         take;
  logic         sys_answer;
  hcp_answer_t  answer_kind;

  // ----------------------------------------------------------------
  // Answer decoding
  // ----------------------------------------------------------------
  // Any kind of system bus answer ends the wait state
  function automatic logic answered(input logic done,
                                    input logic err,
                                    input logic rtry);
    answered = done | err | rtry;
  endfunction

  // Error beats retry beats done, so one strobe per transaction
  function automatic hcp_answer_t pick_answer(input logic err,
                                              input logic rtry);
    if (err) begin
      pick_answer = HCP_ANS_ERR;
    end else if (rtry) begin
      pick_answer = HCP_ANS_RETRY;
    end else begin
      pick_answer = HCP_ANS_ACK;
    end
  endfunction

  assign en = port_en_in & cfg_done_in;
  assign hit = en & ~chip_select_low_n_in & chip_select_high_in
             & ~transfer_start_n_in;
  // Only an idle port takes a cycle; starts while busy are dropped
  assign take        = hit & (state_reg == HCP_IDLE);
  assign sys_answer  = answered(sys_done_in, sys_error_in, sys_retry_in);
  assign answer_kind = pick_answer(sys_error_in, sys_retry_in);

  always_comb begin
    pin_req.sel   = hit;
    pin_req.read  = read_not_write_in;
    pin_req.size  = transfer_size_in;
    pin_req.burst = ~burst_indicator_n_in;
    pin_req.addr  = addr_in;
    pin_req.wdata = data_in;
    pin_req.wpar  = byte_lane_parity_in;
  end

  // ----------------------------------------------------------------
  // Parity
  // ----------------------------------------------------------------
  hcp_parity u_rpar (
    .data_in      (sys_rdata_in),
    .width_sel_in (width_sel_in),
    .parity_out   (rd_par),
    .lanes_out    (lanes)
  );

  hcp_parity u_wpar (
    .data_in      (data_in),
    .width_sel_in (width_sel_in),
    .parity_out   (wr_par),
    .lanes_out    ()
  );

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HCP_IDLE: begin
        if (take) begin
          state_next = HCP_WAIT;
        end
      end
      // No time limit: the system bus always answers
      HCP_WAIT: begin
        if (sys_answer) begin
          state_next = HCP_RESP;
        end
      end
      HCP_RESP: begin
        state_next = HCP_HOLD;
      end
      // One turnaround cycle so the master sees the answer released
      HCP_HOLD: begin
        state_next = HCP_IDLE;
      end
      default: begin
        state_next = HCP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= HCP_IDLE;
    end else if (!en) begin
      state_reg <= HCP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // System bus request, clocked by the host bus clock
  // ----------------------------------------------------------------
  // A plain wire so both sides see the very same edges
  assign sys_clk_out = mclk_in;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sreq_reg <= '0;
    end else if (take) begin
      sreq_reg.valid <= 1'b1;
      sreq_reg.read  <= pin_req.read;
      sreq_reg.size  <= pin_req.size;
      sreq_reg.burst <= pin_req.burst;
      sreq_reg.addr  <= pin_req.addr;
      sreq_reg.wdata <= pin_req.read ? `HCP_DATA_RST : pin_req.wdata;
    end else if (state_reg == HCP_WAIT && sys_answer) begin
      sreq_reg.valid <= 1'b0;
    end else if (!en) begin
      // Disabling the port abandons a pending request
      sreq_reg.valid <= 1'b0;
    end
  end

  always_comb begin
    sys_valid_out = sreq_reg.valid;
    sys_read_out  = sreq_reg.read;
    sys_size_out  = sreq_reg.size;
    sys_burst_out = sreq_reg.burst;
    sys_addr_out  = sreq_reg.addr;
    sys_wdata_out = sreq_reg.wdata;
  end

  // Write parity check on lanes in use
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      perr_reg <= 1'b0;
    end else if (take && !pin_req.read) begin
      perr_reg <= |((wr_par ^ pin_req.wpar) & lanes);
    end else begin
      perr_reg <= 1'b0;
    end
  end
  assign wr_parity_err_out = perr_reg;

  // ----------------------------------------------------------------
  // Answer strobes: exactly one per transaction, error beats retry
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_n_reg  <= 1'b1;
      tea_n_reg  <= 1'b1;
      rtry_n_reg <= 1'b1;
    end else if (state_reg == HCP_WAIT && en && sys_answer) begin
      tea_n_reg  <= (answer_kind != HCP_ANS_ERR);
      rtry_n_reg <= (answer_kind != HCP_ANS_RETRY);
      ack_n_reg  <= (answer_kind != HCP_ANS_ACK);
    end else begin
      ack_n_reg  <= 1'b1;
      tea_n_reg  <= 1'b1;
      rtry_n_reg <= 1'b1;
    end
  end

  // Read data and parity launched with the acknowledge
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= `HCP_DATA_RST;
      rpar_reg  <= `HCP_PAR_RST;
      drive_reg <= 1'b0;
    end else if (state_reg == HCP_WAIT && en && sreq_reg.read
                 && sys_answer && answer_kind == HCP_ANS_ACK) begin
      rdata_reg <= sys_rdata_in;
      rpar_reg  <= rd_par;
      drive_reg <= 1'b1;
    end else begin
      // Drive lasts the acknowledge cycle only, then the lines turn round
      drive_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin mux
  // ----------------------------------------------------------------
  logic [3:0]  mux_ctl;
  logic [3:0]  mux_ctl_oe;
  logic [35:0] mux_dat;
  logic [35:0] mux_dat_oe;

  hcp_gpio u_gpio (
    .port_en_in     (en),
    .port_ctl_in    ({1'b1, rtry_n_reg, tea_n_reg, ack_n_reg}),
    .user_ctl_in    (user_ctl_in),
    .user_ctl_oe_in (user_ctl_oe_in),
    .port_dat_in    ({rpar_reg, rdata_reg}),
    .port_dat_oe_in (drive_reg),
    .user_dat_in    (user_dat_in),
    .user_dat_oe_in (user_dat_oe_in),
    .ctl_out        (mux_ctl),
    .ctl_oe_out     (mux_ctl_oe),
    .dat_out        (mux_dat),
    .dat_oe_out     (mux_dat_oe)
  );

  // Registered pins; port enable change takes effect one cycle later
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_out    <= `HCP_CTL_IDLE;
      ctl_oe_out <= `HCP_CTL_OFF;
      dat_out    <= `HCP_PIN_RST;
      dat_oe_out <= `HCP_PIN_RST;
    end else begin
      ctl_out    <= mux_ctl;
      ctl_oe_out <= mux_ctl_oe;
      dat_out    <= mux_dat;
      dat_oe_out <= mux_dat_oe;
    end
  end

endmodule

// >>> hcp_port_monitor.sv
`timescale 1ns/1ps
module hcp_port_monitor
  import hcp_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        port_en_in,
  input wire logic        cfg_done_in,
  input wire logic        chip_select_low_n_in,
  input wire logic        chip_select_high_in,
  input wire logic        transfer_start_n_in,
  input wire logic [3:0]  user_ctl_in,
  input wire logic [35:0] user_dat_oe_in,
  input wire logic        sys_done_in,
  input wire logic        sys_error_in,
  input wire logic        sys_retry_in,
  input wire logic [31:0] sys_rdata_in,
  input wire logic        sys_valid_out,
  input wire logic        sys_read_out,
  input wire logic [3:0]  ctl_out,
  input wire logic [35:0] dat_out,
  input wire logic [35:0] dat_oe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic en;
  assign en = port_en_in && cfg_done_in;
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_take;
    en && !chip_select_low_n_in && chip_select_high_in &&
      !transfer_start_n_in && !sys_valid_out && ctl_out[2:0] == 3'h7;
  endsequence
  sequence s_done;
    en && sys_valid_out && sys_done_in && !sys_error_in && !sys_retry_in;
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_take; s_take |=> sys_valid_out; endproperty
  a_take: assert property (p_take) else $error("start not forwarded");
  property p_ack; s_done |-> ##2 ctl_out[2:0] == 3'h6; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_err;
    en && sys_valid_out && sys_error_in |-> ##2 ctl_out[2:0] == 3'h5;
  endproperty
  a_err: assert property (p_err) else $error("error ack missing");
  property p_retry;
    en && sys_valid_out && sys_retry_in && !sys_error_in
      |-> ##2 ctl_out[2:0] == 3'h3;
  endproperty
  a_retry: assert property (p_retry) else $error("retry missing");
  property p_rd_data;
    s_done ##0 sys_read_out |-> ##2 dat_out[31:0] == $past(sys_rdata_in, 2)
      && dat_oe_out == 36'hF_FFFF_FFFF;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data bad");
  property p_wr_hiz;
    en && $past(en) && !ctl_out[0] && !sys_read_out |-> dat_oe_out == 36'h0;
  endproperty
  a_wr_hiz: assert property (p_wr_hiz) else $error("write drove data");
  property p_one;
    en && $past(en) && ctl_out[2:0] != 3'h7 |=> ctl_out[2:0] == 3'h7;
  endproperty
  a_one: assert property (p_one) else $error("strobe too long");
  property p_onehot;
    en && $past(en) |-> $countones(~ctl_out[2:0]) <= 1;
  endproperty
  a_onehot: assert property (p_onehot) else $error("two answers");
  property p_nosel;
    en && (chip_select_low_n_in || !chip_select_high_in) && !sys_valid_out
      |=> !sys_valid_out;
  endproperty
  a_nosel: assert property (p_nosel) else $error("unselected taken");
  property p_gpio;
    !port_en_in && cfg_done_in && $past(!port_en_in)
      |-> ctl_out == $past(user_ctl_in) && dat_oe_out == $past(user_dat_oe_in);
  endproperty
  a_gpio: assert property (p_gpio) else $error("user io not passed");
endmodule
bind hcp_port hcp_port_monitor u_hcp_port_monitor (.mclk_in, .rst_n_in,
  .port_en_in, .cfg_done_in, .chip_select_low_n_in, .chip_select_high_in,
  .transfer_start_n_in, .user_ctl_in, .user_dat_oe_in, .sys_done_in,
  .sys_error_in, .sys_retry_in, .sys_rdata_in, .sys_valid_out,
  .sys_read_out, .ctl_out, .dat_out, .dat_oe_out);

// >>> hcp_master_model.sv
`timescale 1ns/1ps
module hcp_master_model (
  input  wire logic        mclk_in,
  input  wire logic [3:0]  ctl_in,
  input  wire logic [35:0] dat_in,
  input  wire logic [35:0] dat_oe_in,
  output logic             cs_low_n_out,
  output logic             cs_high_out,
  output logic             start_n_out,
  output logic             rnw_out,
  output logic      [1:0]  size_out,
  output logic             burst_n_out,
  output logic      [17:0] addr_out,
  output logic      [31:0] data_out,
  output logic      [3:0]  par_out
);
  initial begin
    {cs_low_n_out, cs_high_out, start_n_out, rnw_out} = 4'hB;
    {size_out, burst_n_out, addr_out} = 21'h1F_FFFF;
    {data_out, par_out} = 36'h0;
  end
  // Holds the request until the answer is sampled, then deselects
  task automatic run(input logic rd, input logic [1:0] sz, input logic bn,
                     input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] p, input logic sel,
                     output logic [2:0] ans, output logic [35:0] dat,
                     output logic [35:0] oe);
    @(posedge mclk_in);
    #2;
    cs_low_n_out = !sel;
    cs_high_out = 1'b1;
    start_n_out = 1'b0;
    rnw_out = rd;
    size_out = sz;
    burst_n_out = bn;
    addr_out = a;
    data_out = rd ? ~data_out : d;
    par_out = rd ? ~par_out : p;
    @(posedge mclk_in);
    #2;
    start_n_out = 1'b1;
    ans = 3'h7;
    for (int n = 0; n < 12 && ans == 3'h7; n++) begin
      @(posedge mclk_in);
      #1;
      ans = ctl_in[2:0];
      dat = dat_in;
      oe = dat_oe_in;
    end
    @(posedge mclk_in);
    #2;
    cs_low_n_out = 1'b1;
    // Released lines must not keep the last value
    data_out = ~data_out;
    par_out = ~par_out;
  endtask
endmodule

// >>> processor_bus_slave_port_test.sv
`timescale 1ns/1ps
module processor_bus_slave_port_test;
  import hcp_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        port_en_in = 1'b1;
  logic        cfg_done_in = 1'b1;
  logic [1:0]  width_sel_in = 2'h2;
  logic [3:0]  user_ctl_in = 4'hA;
  logic [3:0]  user_ctl_oe_in = 4'hD;
  logic [35:0] user_dat_in = 36'h9_1234_5678;
  logic [35:0] user_dat_oe_in = 36'hF_0000_FFFF;
  logic        sys_done_in = 1'b0;
  logic        sys_error_in = 1'b0;
  logic        sys_retry_in = 1'b0;
  logic [31:0] sys_rdata_in = 32'h0;
  logic        chip_select_low_n_in, chip_select_high_in, transfer_start_n_in;
  logic        read_not_write_in, burst_indicator_n_in, sys_clk_out;
  logic        sys_valid_out, sys_read_out, sys_burst_out, wr_parity_err_out;
  logic [1:0]  transfer_size_in, sys_size_out;
  logic [17:0] addr_in, sys_addr_out;
  logic [31:0] data_in, sys_wdata_out, rsp_data;
  logic [3:0]  byte_lane_parity_in, ctl_out, ctl_oe_out;
  logic [35:0] dat_out, dat_oe_out;
  logic [2:0]  rsp_kind = 3'h1;
  int          rsp_wait = 0, wcnt = 0, perr = 0, err_count = 0, checks = 0;

  always #12.5 mclk_in = ~mclk_in;

  hcp_port u_hcp_port (.mclk_in, .rst_n_in, .port_en_in, .cfg_done_in,
    .width_sel_in, .chip_select_low_n_in, .chip_select_high_in,
    .transfer_start_n_in, .read_not_write_in, .transfer_size_in,
    .burst_indicator_n_in, .addr_in, .data_in, .byte_lane_parity_in,
    .user_ctl_in, .user_ctl_oe_in, .user_dat_in, .user_dat_oe_in,
    .sys_done_in, .sys_error_in, .sys_retry_in, .sys_rdata_in, .sys_clk_out,
    .sys_valid_out, .sys_read_out, .sys_size_out, .sys_burst_out,
    .sys_addr_out, .sys_wdata_out, .wr_parity_err_out, .ctl_out,
    .ctl_oe_out, .dat_out, .dat_oe_out);

  hcp_master_model u_hcp_master_model (.mclk_in, .ctl_in(ctl_out),
    .dat_in(dat_out), .dat_oe_in(dat_oe_out),
    .cs_low_n_out(chip_select_low_n_in), .cs_high_out(chip_select_high_in),
    .start_n_out(transfer_start_n_in), .rnw_out(read_not_write_in),
    .size_out(transfer_size_in), .burst_n_out(burst_indicator_n_in),
    .addr_out(addr_in), .data_out(data_in), .par_out(byte_lane_parity_in));

  // ------------------------------------------------------------
  // System bus side: answers after rsp_wait cycles of valid
  // ------------------------------------------------------------
  always begin
    @(posedge mclk_in);
    #2;
    {sys_error_in, sys_retry_in, sys_done_in} = 3'h0;
    sys_rdata_in = ~sys_rdata_in;
    if (sys_valid_out === 1'b1 && wcnt == rsp_wait) begin
      {sys_error_in, sys_retry_in, sys_done_in} = rsp_kind;
      sys_rdata_in = rsp_data;
    end
    wcnt = (sys_valid_out === 1'b1) ? wcnt + 1 : 0;
    if (wr_parity_err_out === 1'b1) perr++;
  end

  task automatic chk(input string nm, input logic [35:0] e, logic [35:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Even parity, lane 0 on the most significant byte
  function automatic logic [3:0] epar(logic [31:0] d, logic [1:0] w);
    logic [3:0] m;
    m = (w == 2'h0) ? 4'h1 : (w == 2'h1) ? 4'h3 : 4'hF;
    return {^d[7:0], ^d[15:8], ^d[23:16], ^d[31:24]} & m;
  endfunction

  task automatic xfer(input logic rd, logic [1:0] sz, logic [31:0] d,
                      logic [3:0] p, logic [2:0] kind, int wt, logic sel,
                      logic [2:0] ea);
    logic [2:0]  ans;
    logic [35:0] dat, oe, req;
    rsp_kind = kind;
    rsp_wait = wt;
    rsp_data = d;
    u_hcp_master_model.run(rd, sz, rd, {16'h0, sz}, d, p, sel, ans, dat, oe);
    chk("answer", {33'h0, ea}, {33'h0, ans});
    if (ea == 3'h6 && rd) begin
      chk("rdata", {epar(d, width_sel_in), d}, dat);
      chk("rd_oe", 36'hF_FFFF_FFFF, oe);
    end
    if (ea == 3'h6 && !rd) begin
      chk("wr_oe", 36'h0, oe);
      chk("wdata", {4'h0, d}, {4'h0, sys_wdata_out});
      req = {15'h0, sys_size_out, sys_burst_out, sys_addr_out};
      chk("req", {15'h0, sz, 1'b1, 16'h0, sz}, req);
    end
  endtask

  task automatic t_reads;
    logic [1:0] sz [3] = '{2'h1, 2'h2, 2'h0};
    for (int w = 0; w < 3; w++) begin
      width_sel_in = w[1:0];
      xfer(1'b1, sz[w], 32'hA5C3_0F71 ^ w, 4'h0, 3'h1, w, 1'b1, 3'h6);
    end
    #1;
    chk("sys_clk", 36'h1, {35'h0, sys_clk_out});
  endtask

  task automatic t_writes;
    int p0;
    p0 = perr;
    xfer(1'b0, 2'h0, 32'h3C96_E17B, epar(32'h3C96_E17B, 2'h2), 3'h1, 1,
         1'b1, 3'h6);
    chk("par_ok", 36'h0, 36'(perr - p0));
    xfer(1'b0, 2'h2, 32'h0000_0100, 4'h0, 3'h1, 0, 1'b1, 3'h6);
    repeat (3) @(posedge mclk_in);
    chk("par_bad", 36'h1, 36'(perr - p0));
  endtask

  task automatic t_faults;
    xfer(1'b1, 2'h0, 32'h0, 4'h0, 3'h7, 0, 1'b1, 3'h5);
    xfer(1'b0, 2'h1, 32'h5, 4'h1, 3'h2, 2, 1'b1, 3'h3);
    xfer(1'b0, 2'h1, 32'h5, 4'h1, 3'h1, 0, 1'b1, 3'h6);
    xfer(1'b1, 2'h0, 32'h1, 4'h0, 3'h1, 0, 1'b0, 3'h7);
  endtask

  task automatic t_user_io;
    port_en_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    chk("user_ctl", {32'h0, user_ctl_in}, {32'h0, ctl_out});
    chk("user_dat", user_dat_in, dat_out);
    chk("user_oe", {32'h0, user_ctl_oe_in}, {32'h0, ctl_oe_out});
    chk("user_dat_oe", user_dat_oe_in, dat_oe_out);
    #1;
    port_en_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk("port_oe", 36'h7, {32'h0, ctl_oe_out});
  endtask

  task automatic wrap_up;
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk_in);
    #2;
    rst_n_in = 1'b1;
    t_reads();
    t_writes();
    t_faults();
    t_user_io();
    t_reads();
    wrap_up();
  end

  initial begin
    #(25 * 3000);
    err_count++;
    wrap_up();
  end
endmodule
